// [exc_pkg.sv]
// Package for the exception entry unit: vectors, status and cause layouts, types.
// Assumes a single 200 MHz CPU clock and a synchronous active-low reset.
`default_nettype none
package exc_pkg;
	// Clock rate and the latest allowed vector fetch delay.
	localparam int CLK_MHZ = 200;
	localparam int FETCH_DELAY_NS = 5;
	localparam int FETCH_DELAY_CYC = (FETCH_DELAY_NS * CLK_MHZ) / 1000;
	// Avalon register word offsets (byte addresses).
	localparam logic [7:0] STATUS_OFS = 8'h00;
	localparam logic [7:0] CAUSE_OFS = 8'h04;
	localparam logic [7:0] RESTART_OFS = 8'h08;
	localparam logic [7:0] FAULT_ADDR_OFS = 8'h0c;
	localparam logic [7:0] RETURN_OFS = 8'h10;
	// Vector addresses.
	localparam logic [31:0] VEC_UTLB_CACHED = 32'h8000_0000;
	localparam logic [31:0] VEC_GEN_CACHED = 32'h8000_0080;
	localparam logic [31:0] VEC_UTLB_UNCACHED = 32'hbfc0_0100;
	localparam logic [31:0] VEC_GEN_UNCACHED = 32'hbfc0_0180;
	localparam logic [31:0] VEC_RESET = 32'hbfc0_0000;
	// Status field positions: stack of {user,ie} pairs, mask and vector select.
	localparam int SR_IE_CUR = 0;
	localparam int SR_KU_CUR = 1;
	localparam int SR_STACK_W = 6;
	localparam int SR_IMASK_LO = 8;
	localparam int SR_BEV = 22;
	localparam logic [31:0] SR_RESET = 32'h0040_0000;
	localparam logic [31:0] SR_WR_MASK = 32'h0040_ff3f;
	// Cause layout: code in bits 6:2, pending interrupts 15:8, delay slot 31.
	localparam int CAUSE_CODE_LO = 2;
	localparam int CAUSE_IP_LO = 8;
	localparam int CAUSE_BD = 31;
	localparam int NUM_IRQ = 8;
	// Cause codes.
	localparam logic [4:0] CODE_INT = 5'h00;
	localparam logic [4:0] CODE_TLBL = 5'h02;
	localparam logic [4:0] CODE_ADEL = 5'h04;
	localparam logic [4:0] CODE_ADES = 5'h05;
	// Fault reported by a pipeline stage.
	typedef struct packed {
		logic valid;
		logic [4:0] code;
		logic utlb;
		logic addr_fault;
		logic [31:0] addr;
	} fault_s;
	// One pipeline stage's instruction identity.
	typedef struct packed {
		logic valid;
		logic [31:0] pc;
		logic in_delay_slot;
	} stage_s;
	typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_FLUSH} mode_e;
	// All state of the unit.
	typedef struct packed {
		mode_e mode;
		logic [31:0] status;
		logic [31:0] cause;
		logic [31:0] restart_pc;
		logic [31:0] fault_addr;
		logic [NUM_IRQ-1:0] irq_s1;
		logic [NUM_IRQ-1:0] irq_s2;
		logic redirect;
		logic [31:0] redirect_pc;
		logic rdvalid;
		logic [31:0] rdata;
	} state_s;
endpackage
`default_nettype wire

// [cpu_exception_entry_unit.sv]
// Exception entry and return unit of a five-stage 32-bit pipeline.
// Assumes the pipeline reports faults per stage and obeys the flush output.
//
// Overview of operation
// - Exception loads restart address register.
// - Push mode/enable stack, enter kernel, disable.
// - Record cause; address faults capture address.
// - Cached vectors: miss 0x80000000, others +128.
// - Boot select: uncached 0xbfc00100 and 0xbfc00180.
// - Reset vectors to 0xbfc00000.
// - Vector fetch within one clock.
// - Interrupt: memory-stage instruction completes last.
// - Interrupt restart at ALU-stage instruction.
// - Interrupts synchronised, seen at second edge.
// - Younger instructions nullified, no state change.
// - Multiply/divide results exempt from nullification.
// - Float unit writes only when exception-free.
// - Cause code masked 0x7c is word index.
// - Return pops mode stack in jump delay.
// - Interrupt sources individually maskable.
// - No privilege violation in kernel mode.
// - Delay-slot fault restarts at branch, flag set.
// - Early exceptions wait for older instructions.
`default_nettype none
module cpu_exception_entry_unit (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [exc_pkg::NUM_IRQ-1:0] irq_in,
	input wire exc_pkg::fault_s fault_fetch,
	input wire exc_pkg::fault_s fault_decode,
	input wire exc_pkg::fault_s fault_alu,
	input wire exc_pkg::fault_s fault_mem,
	input wire exc_pkg::stage_s stage_alu,
	input wire exc_pkg::stage_s stage_mem,
	input wire logic priv_access,
	input wire logic return_exec,
	input wire logic muldiv_start,
	input wire logic fpu_op_clean,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic fetch_redirect,
	output logic [31:0] fetch_pc,
	output logic flush_alu,
	output logic flush_mem,
	output logic muldiv_commit,
	output logic fpu_write_ok,
	output logic kernel_mode
);
	exc_pkg::state_s state_reg;
	exc_pkg::state_s state_next;
	exc_pkg::fault_s take;
	logic irq_take;
	logic any_take;
	logic [31:0] vec;
	logic [31:0] epc_src;
	logic bd_src;
	logic [4:0] priv_code;

	// Picks the vector for a fault from the boot select and miss kind.
	function automatic logic [31:0] pick_vec(input logic boot_vector_select, input logic utlb);
		if (boot_vector_select) begin
			pick_vec = utlb ? exc_pkg::VEC_UTLB_UNCACHED : exc_pkg::VEC_GEN_UNCACHED;
		end else begin
			pick_vec = utlb ? exc_pkg::VEC_UTLB_CACHED : exc_pkg::VEC_GEN_CACHED;
		end
	endfunction

	// Picks the oldest fault: memory stage first, fetch stage last.
	function automatic exc_pkg::fault_s oldest(input exc_pkg::fault_s m, input exc_pkg::fault_s a,
		input exc_pkg::fault_s d, input exc_pkg::fault_s f);
		if (m.valid) oldest = m;
		else if (a.valid) oldest = a;
		else if (d.valid) oldest = d;
		else oldest = f;
	endfunction

	// Decides what is taken this cycle and where the restart point lies.
	always_comb begin
		priv_code = exc_pkg::CODE_ADEL;
		take = oldest(fault_mem, fault_alu, fault_decode, fault_fetch);
		// A privileged access only faults outside kernel mode.
		if (!take.valid && priv_access && state_reg.status[exc_pkg::SR_KU_CUR]) begin
			take = '0;
			take.valid = 1'b1;
			take.code = priv_code;
		end
		irq_take = (state_reg.mode == exc_pkg::ST_RUN) && !take.valid
			&& state_reg.status[exc_pkg::SR_IE_CUR]
			&& |(state_reg.irq_s2 & state_reg.status[exc_pkg::SR_IMASK_LO +: exc_pkg::NUM_IRQ])
			&& stage_alu.valid;
		any_take = (state_reg.mode == exc_pkg::ST_RUN) && (take.valid || irq_take);
		// Memory-stage faults restart at the memory-stage instruction; interrupts and all other faults at the ALU one.
		if (irq_take) begin
			epc_src = stage_alu.pc;
			bd_src = stage_alu.in_delay_slot;
		end else if (fault_mem.valid) begin
			epc_src = stage_mem.pc;
			bd_src = stage_mem.in_delay_slot;
		end else begin
			epc_src = stage_alu.pc;
			bd_src = stage_alu.in_delay_slot;
		end
		vec = pick_vec(state_reg.status[exc_pkg::SR_BEV], take.valid && take.utlb);
	end

	// Next-state logic for entry, return, interrupt sampling and the register bus.
	always_comb begin
		state_next = state_reg;
		state_next.redirect = 1'b0;
		state_next.rdvalid = 1'b0;
		state_next.irq_s1 = irq_in;
		state_next.irq_s2 = state_reg.irq_s1;
		state_next.cause[exc_pkg::CAUSE_IP_LO +: exc_pkg::NUM_IRQ] = state_reg.irq_s2;
		if (state_reg.mode == exc_pkg::ST_RESET) begin
			state_next.mode = exc_pkg::ST_RUN;
			state_next.redirect = 1'b1;
			state_next.redirect_pc = exc_pkg::VEC_RESET;
		end else if (any_take) begin
			state_next.restart_pc = bd_src ? epc_src - 32'h0000_0004 : epc_src;
			state_next.cause[exc_pkg::CAUSE_BD] = bd_src;
			state_next.cause[exc_pkg::CAUSE_CODE_LO +: 5] =
				irq_take ? exc_pkg::CODE_INT : take.code;
			if (take.valid && take.addr_fault) begin
				state_next.fault_addr = take.addr;
			end
			state_next.status[exc_pkg::SR_STACK_W-1:0] =
				{state_reg.status[3:0], 2'b00};
			state_next.redirect = 1'b1;
			state_next.redirect_pc = vec;
		end else if (return_exec) begin
			state_next.status[exc_pkg::SR_STACK_W-1:0] =
				{state_reg.status[5:4], state_reg.status[5:2]};
		end
		// Register writes take effect at the accepting edge, but are dropped in a cycle that takes an exception.
		if (avs_write && !any_take) begin
			unique case (avs_address)
				exc_pkg::STATUS_OFS: state_next.status = avs_writedata & exc_pkg::SR_WR_MASK;
				exc_pkg::RESTART_OFS: state_next.restart_pc = avs_writedata;
				default: ;
			endcase
		end
		if (avs_read) begin
			state_next.rdvalid = 1'b1;
			unique case (avs_address)
				exc_pkg::STATUS_OFS: state_next.rdata = state_reg.status;
				exc_pkg::CAUSE_OFS: state_next.rdata = state_reg.cause;
				exc_pkg::RESTART_OFS: state_next.rdata = state_reg.restart_pc;
				exc_pkg::FAULT_ADDR_OFS: state_next.rdata = state_reg.fault_addr;
				default: state_next.rdata = 32'h0000_0000;
			endcase
		end
		if (state_reg.rdvalid) begin
			state_next.rdvalid = 1'b0;
		end
	end

	// Registers the whole state; reset enters the reset exception.
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_reg <= '0;
			state_reg.mode <= exc_pkg::ST_RESET;
			state_reg.status <= exc_pkg::SR_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	// Reads wait one cycle for registered data; writes are taken at once.
	assign avs_waitrequest = avs_read && !state_reg.rdvalid;
	assign avs_readdata = state_reg.rdata;
	assign fetch_redirect = state_reg.redirect;
	assign fetch_pc = state_reg.redirect_pc;
	// Younger work is killed; the memory stage survives an interrupt.
	assign flush_alu = any_take;
	assign flush_mem = any_take && !irq_take && fault_mem.valid;
	assign muldiv_commit = muldiv_start;
	assign fpu_write_ok = fpu_op_clean && !any_take;
	assign kernel_mode = !state_reg.status[exc_pkg::SR_KU_CUR];
endmodule
`default_nettype wire

// [irq_source.sv]
// Interrupt source model: holds each requested line as a level.
// Assumes the bench changes its request right after a clock edge.
`default_nettype none
module irq_source (
	input wire logic mclk,
	input wire logic [7:0] set_line,
	output var logic [7:0] irq_in = '0
);
	timeunit 1ns;
	timeprecision 1ps;
	// Lines change once per edge, like a board-level source.
	always @(posedge mclk) irq_in <= set_line;
endmodule
`default_nettype wire

// [exc_checker.sv]
// Port checker for the exception unit, bound to its top module.
// Assumes the single clock mclk and the synchronous reset nrst.
`default_nettype none
module exc_checker (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] irq_in,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic fetch_redirect,
	input wire logic [31:0] fetch_pc,
	input wire logic flush_alu,
	input wire logic flush_mem,
	input wire exc_pkg::fault_s fault_mem,
	input wire logic muldiv_start,
	input wire logic muldiv_commit,
	input wire logic fpu_op_clean,
	input wire logic fpu_write_ok,
	input wire logic kernel_mode
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// An interrupt line raised after a quiet cycle.
	sequence irq_rise;
		!(|irq_in) ##1 (|irq_in);
	endsequence
	AST_RST_VEC: assert property ($rose(nrst) |=>
		fetch_redirect && fetch_pc == exc_pkg::VEC_RESET) else $error("bad reset vector");
	AST_KERNEL: assert property (fetch_redirect |-> kernel_mode) else $error("not kernel");
	AST_PC_HOLD: assert property (!fetch_redirect |-> $stable(fetch_pc)) else $error("pc moved");
	AST_SYNC: assert property (irq_rise |-> !fetch_redirect [*3]) else $error("early irq");
	AST_MULDIV: assert property (muldiv_start |-> muldiv_commit) else $error("no commit");
	AST_FPU: assert property (fpu_write_ok |-> fpu_op_clean) else $error("unsafe fpu");
	AST_WR: assert property (avs_write |-> !avs_waitrequest) else $error("write stalled");
	AST_RD: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("rd");
	// A flush always leads into a vector fetch on the next cycle.
	AST_FLUSH_REDIR: assert property (flush_alu |=> fetch_redirect)
		else $error("flush without redirect");
	// The memory stage is only killed by a fault of its own, never by an interrupt.
	AST_MEM_KEEP: assert property (flush_mem |-> flush_alu && fault_mem.valid)
		else $error("memory stage killed");
	// No float result is written in a cycle that takes an exception.
	AST_FPU_HOLD: assert property (flush_alu |-> !fpu_write_ok)
		else $error("fpu write during exception");
endmodule
bind cpu_exception_entry_unit exc_checker chk (.mclk, .nrst, .irq_in, .avs_read, .avs_write,
	.avs_waitrequest, .fetch_redirect, .fetch_pc, .flush_alu, .flush_mem, .fault_mem,
	.muldiv_start, .muldiv_commit,
	.fpu_op_clean, .fpu_write_ok, .kernel_mode);
`default_nettype wire

// [cpu_exception_entry_unit_tb.sv]
// Self-checking bench for the exception unit with a status and cause model.
// Assumes the package, checker and interrupt source are compiled first.
`default_nettype none
module cpu_exception_entry_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 0, nrst = 0, rd = 0, wr = 0, ret = 0, mds = 0, fcl = 0, prv = 0;
	logic [7:0] adr = 0, irq_set = 0, irq;
	logic [31:0] wd = 0, rdat, fpc, got, st;
	logic wrq, redir;
	exc_pkg::fault_s fa = '0, fm = '0;
	exc_pkg::stage_s sa = '0, sm = '0;
	int mismatches = 0, samples_checked = 0;
	// Unit under test and the interrupt sources.
	cpu_exception_entry_unit dut (.mclk, .nrst, .irq_in(irq), .fault_fetch('0),
		.fault_decode('0), .fault_alu(fa), .fault_mem(fm), .stage_alu(sa), .stage_mem(sm),
		.priv_access(prv), .return_exec(ret), .muldiv_start(mds), .fpu_op_clean(fcl),
		.avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_readdata(rdat), .avs_waitrequest(wrq), .fetch_redirect(redir), .fetch_pc(fpc),
		.flush_alu(), .flush_mem(), .muldiv_commit(), .fpu_write_ok(), .kernel_mode());
	irq_source src (.mclk, .set_line(irq_set), .irq_in(irq));
	// Clock at 200 MHz.
	always #2.5 mclk = ~mclk;
	// Random side traffic; privileged ops must never fault in kernel mode.
	always @(posedge mclk) begin
		mds <= 1'($urandom);
		fcl <= 1'($urandom);
		prv <= 1'($urandom);
	end
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	// Avalon master: holds the request until waitrequest is sampled low; the watchdog ends a hang.
	task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge mclk);
		{rd, wr, adr, wd} <= {!w, w, a, d};
		do @(posedge mclk); while (wrq !== 1'b0);
		got = rdat;
		{rd, wr} <= 2'b0;
	endtask
	// Counts edges until a redirect is sampled high, giving up after eight.
	task automatic wait_redir(output int n);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (redir !== 1'b1 && n < 8);
	endtask
	function automatic exc_pkg::fault_s mk(logic [4:0] c, logic u);
		return '{1'b1, c, u, !u, $urandom};
	endfunction
	// One exception: inject, then check vector, registers and the return pop.
	task automatic take(exc_pkg::fault_s m, a, logic ds, logic [7:0] l);
		int n;
		exc_pkg::fault_s e = m.valid ? m : a;
		logic [31:0] pm = $urandom & 32'h7ffffffc, v;
		v = st[22] ? (e.utlb ? exc_pkg::VEC_UTLB_UNCACHED : exc_pkg::VEC_GEN_UNCACHED) :
			(e.utlb ? exc_pkg::VEC_UTLB_CACHED : exc_pkg::VEC_GEN_CACHED);
		@(posedge mclk);
		{sm, sa, fm, fa, irq_set} <= {1'b1, pm, ds, 1'b1, pm + 32'h4, 1'b0, m, a, l};
		@(posedge mclk);
		{fm, fa} <= '0;
		wait_redir(n);
		irq_set <= 0;
		st = (st & ~32'h3f) | ((st << 2) & 32'h3c);
		chk("latency", l ? 4 : 1, n);
		chk("vector", v, fpc);
		bus(0, exc_pkg::RESTART_OFS, 0);
		chk("restart", m.valid ? pm - {ds, 2'b0} : pm + 4, got);
		bus(0, exc_pkg::CAUSE_OFS, 0);
		chk("cause", {ds, 24'h0, e.code, 2'b0}, got & 32'h8000_007c);
		bus(0, exc_pkg::FAULT_ADDR_OFS, 0);
		if (e.addr_fault) chk("fault address", e.addr, got);
		bus(0, exc_pkg::STATUS_OFS, 0);
		chk("status", st, got);
		ret <= 1;
		@(posedge mclk);
		ret <= 0;
		st = (st & ~32'hf) | ((st >> 2) & 32'hf);
		bus(0, exc_pkg::STATUS_OFS, 0);
		chk("popped status", st, got);
	endtask
	// Holds reset for five edges, then checks the reset vector, its timing and the status.
	task automatic restart();
		int n;
		nrst <= 1'b0;
		repeat (5) @(posedge mclk);
		nrst <= 1'b1;
		st = exc_pkg::SR_RESET;
		wait_redir(n);
		chk("reset latency", 2, n);
		chk("reset vector", exc_pkg::VEC_RESET, fpc);
		bus(0, exc_pkg::STATUS_OFS, 0);
		chk("reset status", st, got);
	endtask
	task end_of_test();
		$display("checks %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Reset, faults with both vector sets, then masked and unmasked interrupts.
	initial begin
		int n;
		void'($urandom(83));
		restart();
		for (int b = 0; b < 2; b++) begin
			take(mk(exc_pkg::CODE_TLBL, 1), '0, 0, 0);
			take(mk(exc_pkg::CODE_ADEL, 0), '0, 1, 0);
			take(mk(exc_pkg::CODE_ADES, 0), mk(exc_pkg::CODE_TLBL, 0), 0, 0);
			bus(1, exc_pkg::STATUS_OFS, 32'h0000_0201);
			st = 32'h0000_0201;
		end
		irq_set <= 8'h01;
		wait_redir(n);
		chk("masked line", 8, n);
		irq_set <= 0;
		take('0, '0, 0, 8'h02);
		restart();
		end_of_test();
	end
	// Watchdog against a hung handshake.
	initial begin
		#10us;
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
